// file: bench/scc_link_host.sv
// Host end of the serial link: sends bytes MSB first, appends a checksum in modes 1 and 2.
// Assumes it shares clk_in with the block under test.
`timescale 1ns/100ps
`default_nettype none
module scc_link_host (
    input wire logic clk_in, // System clock.
    output logic link_clk_out, // Link bit clock, 160 ns period.
    output logic link_data_out, // Serial data.
    output logic link_frame_out // High for a whole frame.
);
    // The link clock rests low between frames, as a real host would.
    initial begin
        link_clk_out = 1'b0;
        link_data_out = 1'b1;
        link_frame_out = 1'b0;
    end
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] b);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? 8'h07 : 8'h00);
        end
        return r;
    endfunction : crc_step
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            link_data_out <= b[i];
            repeat (4) @(posedge clk_in);
            link_clk_out <= 1'b1;
            repeat (8) @(posedge clk_in);
            link_clk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
    endtask : put_byte
    // Mode 0 sends no checksum, 1 a good one, 2 a corrupted one.
    task automatic send(input logic [7:0] d [4], input int n, input int mode);
        logic [7:0] c;
        c = 8'h00;
        link_frame_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        for (int k = 0; k < n; k++) begin
            c = crc_step(c, d[k]);
            put_byte(d[k]);
        end
        if (mode != 0) put_byte(mode == 1 ? c : ~c);
        link_frame_out <= 1'b0;
        // A released data line must not keep showing its last bit.
        link_data_out <= ~link_data_out;
        repeat (8) @(posedge clk_in);
    endtask : send
endmodule : scc_link_host
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench of the sequencer control block over Wishbone.
// Assumes scc_pkg is compiled first and the link host model beside it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb;
    import scc_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [ADR_W-1:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
    logic wb_ack_out, irq_out, bist_start_out, seen;
    logic sleep_pin_in = 1'b0, active_request_pin_in = 1'b1;
    logic seq_force_active_set_in = 1'b0, wdt_shdn_we_in = 1'b0;
    logic [1:0] wdt_shdn_val_in = 2'h0, seq_sel_in = 2'h0, slot_sel_in = 2'h0;
    logic deep_shutdown_done_in = 1'b0, deep_shutdown_exit_in = 1'b0;
    logic [NUM_AF-1:0] pp_select_out;
    logic sleep_request_out, run_request_out, force_active_ctrl_out;
    logic [1:0] force_shutdown_field_out;
    logic [NUM_EN-1:0] slot_enables_out;
    wire link_clk_in, link_data_in, link_frame_in;
    int err_count = 0, samples_checked = 0;
    logic [11:0] v;
    int tbl [8][5] = '{'{0,0,2,0,1}, '{0,1,2,0,1}, '{1,0,2,0,1},
        '{1,1,2,0,2}, '{1,1,2,1,1}, '{1,0,2,2,2}, '{1,0,1,0,2},
        '{1,0,3,0,2}};
    always #5 clk_in = ~clk_in;
    scc_top #(.RESUME_CYCLES(20)) u_scc_top (.clk_in, .reset_n_in,
        .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .irq_out, .link_clk_in,
        .link_data_in, .link_frame_in, .sleep_pin_in, .active_request_pin_in,
        .seq_force_active_set_in, .wdt_shdn_we_in, .wdt_shdn_val_in,
        .deep_shutdown_done_in, .deep_shutdown_exit_in, .seq_sel_in,
        .slot_sel_in, .pp_select_out, .sleep_request_out, .run_request_out,
        .force_shutdown_field_out, .force_active_ctrl_out, .bist_start_out,
        .slot_enables_out);
    scc_link_host u_scc_link_host (.clk_in, .link_clk_out(link_clk_in),
        .link_data_out(link_data_in), .link_frame_out(link_frame_in));
    // ****************************************
    // Bus and helper tasks, entered just after a rising edge.
    // ****************************************
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_sel_in <= 4'hF;
        wb_dat_in <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        `CHK("ack", 1'b1, wb_ack_out)
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clk_in);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK("read data", e, q)
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    task automatic watch();
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk_in);
            seen = seen | bist_start_out;
        end
    endtask : watch
    task automatic do_reset(input logic e);
        reset_n_in <= 1'b0;
        tick(8);
        reset_n_in <= 1'b1;
        watch();
        `CHK("bist at power on", e, seen)
        rd(ADR_CTRL, {20'h0, CTRL_RST});
    endtask : do_reset
    task automatic deep(input logic ex);
        deep_shutdown_exit_in <= ex;
        deep_shutdown_done_in <= ~ex;
        @(posedge clk_in);
        deep_shutdown_exit_in <= 1'b0;
        deep_shutdown_done_in <= 1'b0;
        watch();
    endtask : deep
    task automatic frame(input int n, input int mode, input int e);
        logic [7:0] d [4];
        d = '{8'h5A, 8'hC3, 8'h81, 8'h00};
        wb(1'b1, ADR_STATUS, 32'hF);
        u_scc_link_host.send(d, n, mode);
        rd(ADR_STATUS, e);
        `CHK("irq", (e == 2), irq_out)
    endtask : frame
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge clk_in);
        err_count++;
        final_report();
    end
    initial begin
        @(posedge clk_in);
        do_reset(1'b1);
        wb(1'b1, ADR_CTRL, 32'h0);
        // A reset restores the self-test default, so the pulse comes again.
        do_reset(1'b1);
        wb(1'b1, ADR_CTRL, 32'hA00);
        `CHK("drive type", 4'hA, pp_select_out)
        wb(1'b1, ADR_CTRL, 32'h502);
        `CHK("drive type", 4'h5, pp_select_out)
        `CHK("force active", 1'b0, force_active_ctrl_out)
        seq_force_active_set_in <= 1'b1;
        tick(1);
        seq_force_active_set_in <= 1'b0;
        sleep_pin_in <= 1'b1;
        tick(5);
        `CHK("force active", 1'b1, force_active_ctrl_out)
        `CHK("sleep ignored", 1'b0, sleep_request_out)
        rd(ADR_STATE, 32'h7);
        wb(1'b1, ADR_CTRL, 32'h0);
        tick(2);
        `CHK("force active", 1'b0, force_active_ctrl_out)
        `CHK("sleep", 1'b1, sleep_request_out)
        sleep_pin_in <= 1'b0;
        wb(1'b1, ADR_CTRL, 32'h4);
        tick(4);
        `CHK("run", 1'b0, run_request_out)
        `CHK("field", 2'h1, force_shutdown_field_out)
        tick(25);
        `CHK("run", 1'b1, run_request_out)
        rd(ADR_STATUS, 32'h4);
        wdt_shdn_we_in <= 1'b1;
        wdt_shdn_val_in <= 2'h2;
        tick(1);
        wdt_shdn_we_in <= 1'b0;
        tick(4);
        `CHK("field", 2'h2, force_shutdown_field_out)
        `CHK("run", 1'b0, run_request_out)
        tick(25);
        wb(1'b1, ADR_MASK, 32'h2);
        foreach (tbl[i]) begin
            wb(1'b1, ADR_CTRL, (tbl[i][0] << 5) | (tbl[i][1] << 4));
            frame(tbl[i][2], tbl[i][3], tbl[i][4]);
        end
        wb(1'b1, ADR_STATUS, 32'hF);
        wb(1'b1, ADR_SLOT_BASE, 32'hFFFFFFFF);
        rd(ADR_SLOT_BASE, 32'hFFF);
        wb(1'b1, ADR_CTRL, 32'h0);
        deep(1'b0);
        rd(ADR_SLOT_BASE, 32'hFFF);
        wb(1'b1, ADR_CTRL, 32'h1);
        deep(1'b0);
        rd(ADR_SLOT_BASE, 32'h0);
        rd(ADR_CTRL, {20'h0, CTRL_RST});
        rd(ADR_STATUS, 32'h8);
        wb(1'b1, ADR_CTRL, 32'h0);
        deep(1'b1);
        `CHK("bist at deep exit", 1'b0, seen)
        wb(1'b1, ADR_CTRL, 32'h80);
        deep(1'b1);
        `CHK("bist at deep exit", 1'b1, seen)
        for (int i = 0; i < NUM_MAPS; i++) begin
            wb(1'b1, ADR_SLOT_BASE + 8'(4 * i), 32'(12'h111 * i + 12'h800));
        end
        for (int i = 0; i < NUM_MAPS; i++) begin
            v = 12'(12'h111 * i + 12'h800);
            rd(ADR_SLOT_BASE + 8'(4 * i), {20'h0, v});
            seq_sel_in <= 2'(i >> 2);
            slot_sel_in <= 2'(i);
            tick(3);
            `CHK("slot enables", v, slot_enables_out)
        end
        wb(1'b1, 8'h20, 32'hFFFF);
        rd(8'h20, 32'h0);
        final_report();
    end
endmodule : tb
`default_nettype wire

// file: verilog/scc_crc8.sv
// One-byte update of the link checksum, MSB first.
// Pure combinational; the caller holds the running value.
`timescale 1ns/100ps
`default_nettype none
module scc_crc8 (
    input wire logic [7:0] crc_in, // Running checksum.
    input wire logic [7:0] data_in, // Byte to fold in.
    output logic [7:0] crc_out // Updated checksum.
);
    import scc_pkg::*;

    function automatic logic [7:0] fold(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CSUM_POLY) : (r << 1);
        end
        return r;
    endfunction : fold

    assign crc_out = fold(crc_in, data_in);
endmodule : scc_crc8
`default_nettype wire

// file: verilog/scc_pkg.sv
// Shared constants and types of the sequencer control and configuration
// block. Assumes a 100 MHz system clock and a 32-bit Wishbone slave port.
`default_nettype none
package scc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int NUM_EN = 12;
    localparam int NUM_AF = 4;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_SEQ = 4;
    localparam int NUM_MAPS = NUM_SEQ * NUM_SLOTS;
    localparam int ADR_W = 8;
    // ****************************************
    // Register byte offsets.
    // ****************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_MASK = 8'h08;
    localparam logic [7:0] ADR_LINK_LEN = 8'h0C;
    localparam logic [7:0] ADR_STATE = 8'h10;
    localparam logic [7:0] ADR_SLOT_BASE = 8'h40;
    localparam logic [7:0] ADR_SLOT_LAST = 8'h7C;
    // ****************************************
    // Control register fields.
    // ****************************************
    localparam int CTRL_RELOAD = 0;
    localparam int CTRL_FACT = 1;
    localparam int CTRL_FSHDN = 2;
    localparam int CTRL_REQ_CSUM = 4;
    localparam int CTRL_CSUM_EN = 5;
    localparam int CTRL_ST_POR = 6;
    localparam int CTRL_ST_DEEP = 7;
    localparam int CTRL_PP = 8;
    localparam int CTRL_W = 12;
    localparam logic [11:0] CTRL_RST = 12'h040;
    localparam logic [1:0] FSHDN_ACT_PIN = 2'h0;
    // ****************************************
    // Status, mask and state fields.
    // ****************************************
    localparam int ST_FRAME_OK = 0;
    localparam int ST_CSUM_ERR = 1;
    localparam int ST_RESUMED = 2;
    localparam int ST_RELOADED = 3;
    localparam int ST_W = 4;
    localparam logic [11:0] SLOT_RST = 12'h000;
    localparam logic [7:0] LINK_LEN_RST = 8'h02;
    // ****************************************
    // Checksum and timing.
    // ****************************************
    localparam logic [7:0] CSUM_POLY = 8'h07;
    localparam logic [7:0] CSUM_INIT = 8'h00;
    localparam int SHDN_RESUME_US = 10;
    localparam int SHDN_RESUME_CYC = SHDN_RESUME_US * CLK_MHZ;
    typedef enum logic [2:0] {
        LNK_IDLE = 3'b001,
        LNK_RECV = 3'b010,
        LNK_CHECK = 3'b100
    } scc_link_state_t;
endpackage : scc_pkg
`default_nettype wire

// file: verilog/scc_top.sv
// Control and sequence-configuration registers of a 12-channel rail
// sequencer, with a checksum checker on the serial host link.
// Assumes a classic Wishbone master on clk_in and asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module scc_top #(
    parameter int RESUME_CYCLES = scc_pkg::SHDN_RESUME_CYC
) (
    input wire logic clk_in, // 100 MHz clock.
    input wire logic reset_n_in, // Synchronous reset, active low.
    input wire logic wb_cyc_in, // Wishbone cycle.
    input wire logic wb_stb_in, // Wishbone strobe.
    input wire logic wb_we_in, // Wishbone write.
    input wire logic [scc_pkg::ADR_W-1:0] wb_adr_in, // Byte address.
    input wire logic [3:0] wb_sel_in, // Byte lanes.
    input wire logic [31:0] wb_dat_in, // Write data.
    output logic [31:0] wb_dat_out, // Read data.
    output logic wb_ack_out, // Acknowledge.
    output logic irq_out, // Level interrupt, high.
    input wire logic link_clk_in, // Link bit clock pin.
    input wire logic link_data_in, // Link data pin.
    input wire logic link_frame_in, // High for a whole frame.
    input wire logic sleep_pin_in, // Sleep request pin.
    input wire logic active_request_pin_in, // Active pin.
    input wire logic seq_force_active_set_in, // Sequencer sets force-active.
    input wire logic wdt_shdn_we_in, // Watchdog writes the field.
    input wire logic [1:0] wdt_shdn_val_in, // Watchdog field value.
    input wire logic deep_shutdown_done_in, // Deep shutdown states done.
    input wire logic deep_shutdown_exit_in, // Leaving deep shutdown.
    input wire logic [1:0] seq_sel_in, // Sequence being played.
    input wire logic [1:0] slot_sel_in, // Slot being played.
    output logic [scc_pkg::NUM_AF-1:0] pp_select_out, // 1 = push-pull.
    output logic sleep_request_out, // Sleep requested.
    output logic run_request_out, // Active requested.
    output logic [1:0] force_shutdown_field_out, // Current field.
    output logic force_active_ctrl_out, // Current force-active.
    output logic bist_start_out, // Self test start pulse.
    output logic [scc_pkg::NUM_EN-1:0] slot_enables_out // Slot outputs.
);
    import scc_pkg::*;
    localparam int DLY_W = $clog2(RESUME_CYCLES + 1);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (d & m);
    endfunction : merge

    // ****************************************
    // Wishbone decode.
    // ****************************************
    logic ack_reg;
    logic [31:0] rdat_reg;
    wire req = wb_cyc_in & wb_stb_in & ~ack_reg;
    wire wr = req & wb_we_in;
    wire hit_ctrl = wb_adr_in == ADR_CTRL;
    wire hit_stat = wb_adr_in == ADR_STATUS;
    wire hit_mask = wb_adr_in == ADR_MASK;
    wire hit_len = wb_adr_in == ADR_LINK_LEN;
    wire hit_state = wb_adr_in == ADR_STATE;
    wire hit_slot = (wb_adr_in >= ADR_SLOT_BASE) &&
                    (wb_adr_in <= ADR_SLOT_LAST);
    wire [3:0] slot_idx = wb_adr_in[5:2];
    wire ctrl_we = wr & hit_ctrl;
    wire slot_we = wr & hit_slot;

    // ****************************************
    // Control fields.
    // ****************************************
    logic reload_reg, force_active_reg, req_csum_reg, csum_en_reg;
    logic st_por_reg, st_deep_reg, por_pending_reg;
    logic [1:0] fshdn_reg;
    logic [NUM_AF-1:0] pp_reg;
    logic [ST_W-1:0] status_reg, mask_reg;
    logic [7:0] len_reg;
    logic [NUM_EN-1:0] slot_map_reg [NUM_MAPS];
    logic [DLY_W-1:0] dly_cnt_reg;
    logic [1:0] slp_s, act_s;
    logic [2:0] lclk_s, lfrm_s;
    logic [1:0] ldat_s;

    wire [11:0] ctrl_rd = {pp_reg, st_deep_reg, st_por_reg, csum_en_reg,
                           req_csum_reg, fshdn_reg, force_active_reg,
                           reload_reg};
    wire [31:0] ctrl_w = merge({20'h0, ctrl_rd}, wb_dat_in, wb_sel_in);
    wire [31:0] slot_m = merge({20'h0, slot_map_reg[slot_idx]}, wb_dat_in,
                               wb_sel_in);
    wire do_reload = deep_shutdown_done_in & reload_reg;
    wire fa_next = seq_force_active_set_in |
                   (force_active_reg & ~(ctrl_we & ~ctrl_w[CTRL_FACT]));
    wire resume_now = (fshdn_reg != FSHDN_ACT_PIN) &&
                      (dly_cnt_reg == DLY_W'(RESUME_CYCLES - 1));

    always_ff @(posedge clk_in) begin
        if (!reset_n_in || do_reload) begin
            {pp_reg, st_deep_reg, st_por_reg, csum_en_reg, req_csum_reg,
             reload_reg} <= {CTRL_RST[11:4], CTRL_RST[0]};
        end else if (ctrl_we) begin
            reload_reg <= ctrl_w[CTRL_RELOAD];
            req_csum_reg <= ctrl_w[CTRL_REQ_CSUM];
            csum_en_reg <= ctrl_w[CTRL_CSUM_EN];
            st_por_reg <= ctrl_w[CTRL_ST_POR];
            st_deep_reg <= ctrl_w[CTRL_ST_DEEP];
            pp_reg <= ctrl_w[CTRL_PP +: NUM_AF];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            force_active_reg <= CTRL_RST[CTRL_FACT];
        end else begin
            force_active_reg <= fa_next;
        end
    end

    // The watchdog wins a tie so a software write cannot mask its shutdown.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            fshdn_reg <= CTRL_RST[CTRL_FSHDN +: 2];
            dly_cnt_reg <= '0;
        end else if (wdt_shdn_we_in) begin
            fshdn_reg <= wdt_shdn_val_in;
            dly_cnt_reg <= '0;
        end else if (ctrl_we) begin
            fshdn_reg <= ctrl_w[CTRL_FSHDN +: 2];
            dly_cnt_reg <= '0;
        end else if (resume_now) begin
            fshdn_reg <= FSHDN_ACT_PIN;
            dly_cnt_reg <= '0;
        end else if (fshdn_reg != FSHDN_ACT_PIN) begin
            dly_cnt_reg <= dly_cnt_reg + DLY_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in || do_reload) begin
            for (int i = 0; i < NUM_MAPS; i++) begin
                slot_map_reg[i] <= SLOT_RST;
            end
        end else if (slot_we) begin
            slot_map_reg[slot_idx] <= slot_m[NUM_EN-1:0];
        end
    end

    // ****************************************
    // Pin synchronisers.
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            {slp_s, act_s, lclk_s, lfrm_s, ldat_s} <= '0;
        end else begin
            slp_s <= {slp_s[0], sleep_pin_in};
            act_s <= {act_s[0], active_request_pin_in};
            lclk_s <= {lclk_s[1:0], link_clk_in};
            lfrm_s <= {lfrm_s[1:0], link_frame_in};
            ldat_s <= {ldat_s[0], link_data_in};
        end
    end

    // ****************************************
    // Link checksum checker.
    // ****************************************
    scc_link_state_t lnk_reg;
    logic [7:0] shift_reg, crc_reg, bytes_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] crc_upd;
    wire lclk_rise = lclk_s[1] & ~lclk_s[2];
    wire [7:0] byte_in = {shift_reg[6:0], ldat_s[1]};
    wire with_sum = {1'b0, bytes_reg} == ({1'b0, len_reg} + 9'h001);
    wire no_sum = bytes_reg == len_reg;
    wire sum_bad = (bit_cnt_reg != 3'h0) ||
                   (with_sum ? (crc_reg != 8'h00) :
                    (no_sum ? req_csum_reg : 1'b1));
    wire check = lnk_reg == LNK_CHECK;
    wire err_ev = check & csum_en_reg & sum_bad;
    wire ok_ev = check & ~err_ev;

    scc_crc8 u_crc (
        .crc_in(crc_reg),
        .data_in(byte_in),
        .crc_out(crc_upd)
    );

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            lnk_reg <= LNK_IDLE;
            shift_reg <= 8'h00;
            crc_reg <= CSUM_INIT;
            bytes_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
        end else begin
            case (lnk_reg)
                LNK_IDLE: begin
                    crc_reg <= CSUM_INIT;
                    bytes_reg <= 8'h00;
                    bit_cnt_reg <= 3'h0;
                    if (lfrm_s[1]) begin
                        lnk_reg <= LNK_RECV;
                    end
                end
                LNK_RECV: begin
                    if (!lfrm_s[1]) begin
                        lnk_reg <= LNK_CHECK;
                    end else if (lclk_rise) begin
                        shift_reg <= byte_in;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == 3'h7) begin
                            crc_reg <= crc_upd;
                            if (bytes_reg != 8'hFF) begin
                                bytes_reg <= bytes_reg + 8'h01;
                            end
                        end
                    end
                end
                default: lnk_reg <= LNK_IDLE;
            endcase
        end
    end

    // ****************************************
    // Status, interrupt, outputs and bus answer.
    // ****************************************
    wire [ST_W-1:0] events = {do_reload, resume_now & ~wdt_shdn_we_in &
                              ~ctrl_we, err_ev, ok_ev};
    wire [31:0] wdat_m = merge(32'h0, wb_dat_in, wb_sel_in);
    wire [ST_W-1:0] w1c = (wr & hit_stat) ? wdat_m[ST_W-1:0] : '0;
    wire [31:0] rd_mux =
        hit_ctrl ? {20'h0, ctrl_rd} :
        hit_stat ? {28'h0, status_reg} :
        hit_mask ? {28'h0, mask_reg} :
        hit_len ? {24'h0, len_reg} :
        hit_state ? {28'h0, irq_out, force_active_reg, act_s[1], slp_s[1]} :
        hit_slot ? {20'h0, slot_map_reg[slot_idx]} : 32'h0;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            status_reg <= '0;
            mask_reg <= '0;
            len_reg <= LINK_LEN_RST;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
            irq_out <= 1'b0;
            por_pending_reg <= 1'b1;
            bist_start_out <= 1'b0;
            sleep_request_out <= 1'b0;
            run_request_out <= 1'b0;
            slot_enables_out <= SLOT_RST;
        end else begin
            status_reg <= (status_reg & ~w1c) | events;
            if (wr && hit_mask) begin
                mask_reg <= wdat_m[ST_W-1:0];
            end
            if (wr && hit_len) begin
                len_reg <= wb_sel_in[0] ? wdat_m[7:0] : len_reg;
            end
            ack_reg <= req;
            rdat_reg <= req ? rd_mux : 32'h0;
            irq_out <= |(status_reg & mask_reg);
            por_pending_reg <= 1'b0;
            bist_start_out <= (por_pending_reg & st_por_reg) |
                (deep_shutdown_exit_in & st_deep_reg);
            sleep_request_out <= ~force_active_reg & slp_s[1];
            run_request_out <= (fshdn_reg == FSHDN_ACT_PIN) & act_s[1];
            slot_enables_out <= slot_map_reg[{seq_sel_in, slot_sel_in}];
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;
    assign pp_select_out = pp_reg;
    assign force_shutdown_field_out = fshdn_reg;
    assign force_active_ctrl_out = force_active_reg;

    // ****************************************
    // Assertions.
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    fact_no_set_a: assert property (!force_active_reg &&
        !seq_force_active_set_in |=> !force_active_reg)
        else $error("force-active set without the sequencer");
    fact_set_a: assert property (seq_force_active_set_in
        |=> force_active_reg) else $error("force-active not set");
    sleep_gate_a: assert property (force_active_reg |=>
        !sleep_request_out) else $error("sleep pin not ignored");
    sleep_pass_a: assert property (!force_active_reg |=>
        sleep_request_out == $past(slp_s[1])) else $error("sleep lost");
    shdn_block_a: assert property (fshdn_reg != FSHDN_ACT_PIN |=>
        !run_request_out) else $error("active pin not blocked");
    shdn_resume_a: assert property (resume_now && !wdt_shdn_we_in &&
        !ctrl_we |=> fshdn_reg == FSHDN_ACT_PIN ##1 run_request_out ==
        $past(act_s[1])) else $error("active pin control not resumed");
    csum_off_a: assert property (check && !csum_en_reg |->
        ok_ev && !err_ev) else $error("checksum judged while off");
    csum_miss_a: assert property (check && csum_en_reg && no_sum &&
        bit_cnt_reg == 3'h0 |-> err_ev == req_csum_reg ##1
        status_reg[ST_CSUM_ERR] == req_csum_reg)
        else $error("missing checksum judged wrongly");
    reload_do_a: assert property (do_reload |=>
        slot_map_reg[0] == SLOT_RST && !reload_reg &&
        status_reg[ST_RELOADED]) else $error("defaults not reloaded");
    reload_skip_a: assert property (deep_shutdown_done_in && !reload_reg
        && !slot_we |=> $stable(slot_map_reg[0]))
        else $error("defaults reloaded while off");
    bist_deep_a: assert property (deep_shutdown_exit_in && st_deep_reg
        |=> bist_start_out) else $error("self test not started");
    drive_hold_a: assert property (!ctrl_we && !do_reload |=>
        $stable(pp_select_out)) else $error("drive type changed");
    slot_play_a: assert property (1'b1 |=> slot_enables_out ==
        $past(slot_map_reg[{seq_sel_in, slot_sel_in}]))
        else $error("slot outputs wrong");

    good_frame_c: cover property (ok_ev && csum_en_reg && with_sum);
    bad_frame_c: cover property (err_ev);
    resume_c: cover property (resume_now);
    reload_c: cover property (do_reload);
endmodule : scc_top
`default_nettype wire
